// ==== logic/pwm_timer_pkg.sv ====
// Register map, field positions, reset values and bus carriers of the PWM timer block.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
package pwm_timer_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam int NUM_FLAGS = 5;
   localparam int NUM_CH = 2;

   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_IRQ_REQ = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_START = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_CMP_B = 8'h1c;
   localparam logic [ADDR_W-1:0] OFS_CMP_C = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_CMP_D = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_CNT0 = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_PERIOD1 = 8'h2c;
   localparam logic [ADDR_W-1:0] OFS_CNT1 = 8'h30;

   localparam int STAT_PM_BIT = 0;
   localparam int STAT_B_BIT = 1;
   localparam int STAT_C_BIT = 2;
   localparam int STAT_D_BIT = 3;
   localparam int STAT_WRAP_BIT = 4;
   localparam int IRQ_CH0_BIT = 1;
   localparam int START_CH0_BIT = 0;
   localparam int START_CH1_BIT = 1;
   localparam int START_W = 4;
   localparam int CLR_SEL_LSB = 5;
   localparam int CLR_SEL_W = 3;
   localparam logic [CLR_SEL_W-1:0] CLR_SEL_PERIOD = 3'b001;

   localparam logic IRQ_MASK_RST = 1'b1;
   localparam logic [START_W-1:0] START_RST = 4'h0;
   localparam logic [CLR_SEL_W-1:0] CLR_SEL_RST = 3'h0;
   localparam logic [NUM_FLAGS-1:0] IRQ_EN_RST = 5'h00;
   localparam logic [CNT_W-1:0] CMP_RST = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axil_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_t;

   typedef struct packed {
      logic [CNT_W-1:0] value;
      logic period_hit;
      logic wrap;
   } cnt_stat_t;

endpackage

// ==== logic/timer_counter.sv ====
// Up counter of one timer channel with run control, period clear and software load.
// Assumes the count source is the block clock itself.
`timescale 1ns/1ps
module timer_counter (
   input wire logic clk,
   input wire logic srst,
   input wire logic run,
   input wire logic clear_on_period,
   input wire logic [pwm_timer_pkg::CNT_W-1:0] period,
   input wire logic load_en,
   input wire logic [pwm_timer_pkg::CNT_W-1:0] load_val,
   output pwm_timer_pkg::cnt_stat_t stat
);
   typedef struct packed {
      logic [pwm_timer_pkg::CNT_W-1:0] value;
   } cnt_state_t;

   cnt_state_t s_r;
   cnt_state_t s_nxt;
   logic hit;
   logic clr;

   assign hit = run && (s_r.value == period);
   assign clr = hit && clear_on_period;
   assign stat.value = s_r.value;
   assign stat.period_hit = hit;
   assign stat.wrap = run && !clr && (s_r.value == pwm_timer_pkg::CNT_MAX);

   always_comb begin
      s_nxt = s_r;
      if (load_en) begin
         s_nxt.value = load_val;
      end else if (clr) begin
         s_nxt.value = '0;
      end else if (run) begin
         s_nxt.value = s_r.value + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // timer_counter

// ==== logic/status_flags.sv ====
// Sticky status flags cleared only by a read of the register followed by a write of zero.
// Assumes rd marks the cycle a read of the status register is accepted.
`timescale 1ns/1ps
module status_flags (
   input wire logic clk,
   input wire logic srst,
   input wire logic [pwm_timer_pkg::NUM_FLAGS-1:0] set,
   input wire logic rd,
   input wire logic wr,
   input wire logic [pwm_timer_pkg::NUM_FLAGS-1:0] wr_data,
   output logic [pwm_timer_pkg::NUM_FLAGS-1:0] flags
);
   typedef struct packed {
      logic [pwm_timer_pkg::NUM_FLAGS-1:0] flags;
      logic [pwm_timer_pkg::NUM_FLAGS-1:0] armed;
   } flag_state_t;

   flag_state_t s_r;
   flag_state_t s_nxt;
   logic [pwm_timer_pkg::NUM_FLAGS-1:0] clr;

   genvar i;
   generate
      for (i = 0; i < pwm_timer_pkg::NUM_FLAGS; i++) begin : g_bit
         assign clr[i] = wr && s_r.armed[i] && !wr_data[i];
      end
   endgenerate

   assign flags = s_r.flags;

   always_comb begin
      s_nxt = s_r;
      s_nxt.flags = set | (s_r.flags & ~clr);
      if (wr) begin
         s_nxt.armed = '0;
      end else if (rd) begin
         s_nxt.armed = s_r.flags;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // status_flags

// ==== logic/pwm_timer_match_irq.sv ====
// Start control, compare-match flags and channel interrupt of a two-channel 16-bit timer.
// Assumes an AXI4-Lite master on clk and a level-sensitive interrupt controller.
//
// Operation
// - Period match flag, status bit 0, sets when counter equals the period register.
// - Period match flag clears only by reading status, then writing zero to it.
// - Status holds overflow at bit 4, match flags D..A at bits 3..0, 7..5 zero.
// - Channel 0 request flag, bit 1, reads one while a request is pending.
// - Channel 0 mask bit 1: zero enables interrupt servicing, one disables it.
// - Start bit 0 runs channel 0 counter, bit 1 runs channel 1.
// - Clear select 001 resets the channel 0 counter to zero on a period match; channel 1 always clears on its period match.
// - Enable bit 0 lets the period match flag raise the channel request.
`timescale 1ns/1ps
module pwm_timer_match_irq (
   input wire logic clk,
   input wire logic srst,
   input pwm_timer_pkg::axil_req_t axi_req,
   output pwm_timer_pkg::axil_rsp_t axi_rsp,
   output logic irq
);
   typedef struct packed {
      pwm_timer_pkg::axil_rsp_t rsp;
      logic aw_held;
      logic [pwm_timer_pkg::ADDR_W-1:0] awaddr;
      logic w_held;
      logic [pwm_timer_pkg::DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic irq_req;
      logic irq_mask;
      logic [pwm_timer_pkg::START_W-1:0] start;
      logic [pwm_timer_pkg::CLR_SEL_W-1:0] clear_sel;
      logic [pwm_timer_pkg::NUM_FLAGS-1:0] irq_en;
      logic [pwm_timer_pkg::CNT_W-1:0] period;
      logic [pwm_timer_pkg::CNT_W-1:0] cmp_b;
      logic [pwm_timer_pkg::CNT_W-1:0] cmp_c;
      logic [pwm_timer_pkg::CNT_W-1:0] cmp_d;
      logic [pwm_timer_pkg::CNT_W-1:0] period1;
      logic irq;
   } top_state_t;

   top_state_t s_r;
   top_state_t s_nxt;

   pwm_timer_pkg::cnt_stat_t cnt0;
   pwm_timer_pkg::cnt_stat_t cnt1;
   pwm_timer_pkg::cnt_stat_t cnt_stat [pwm_timer_pkg::NUM_CH];
   logic [pwm_timer_pkg::NUM_CH-1:0] ch_run;
   logic [pwm_timer_pkg::NUM_CH-1:0] ch_clear;
   logic [pwm_timer_pkg::NUM_CH-1:0] ch_load;
   logic [pwm_timer_pkg::CNT_W-1:0] ch_period [pwm_timer_pkg::NUM_CH];
   logic [pwm_timer_pkg::CNT_W-1:0] cmp_val [pwm_timer_pkg::STAT_B_BIT:pwm_timer_pkg::STAT_D_BIT];
   logic [pwm_timer_pkg::NUM_FLAGS-1:0] flag_set;
   logic [pwm_timer_pkg::NUM_FLAGS-1:0] flags;
   logic run0;
   logic run1;
   logic do_write;
   logic do_read;
   logic wr_lo;
   logic wr_hi;
   logic stat_rd;
   logic stat_wr;
   logic ld0;
   logic ld1;
   logic irq_event;
   logic [pwm_timer_pkg::CNT_W-1:0] wdata16;
   logic [pwm_timer_pkg::DATA_W-1:0] rd_word;
   logic rd_hit;
   logic wr_hit;

   assign run0 = s_r.start[pwm_timer_pkg::START_CH0_BIT];
   assign run1 = s_r.start[pwm_timer_pkg::START_CH1_BIT];

   assign do_write = s_r.aw_held && s_r.w_held && !s_r.rsp.bvalid;
   assign do_read = axi_req.arvalid && s_r.rsp.arready;
   assign wr_lo = do_write && s_r.wstrb[0];
   assign wr_hi = do_write && s_r.wstrb[1];
   assign wdata16 = s_r.wdata[pwm_timer_pkg::CNT_W-1:0];
   assign stat_rd = do_read && (axi_req.araddr == pwm_timer_pkg::OFS_STATUS);
   assign stat_wr = wr_lo && (s_r.awaddr == pwm_timer_pkg::OFS_STATUS);
   assign ld0 = wr_lo && wr_hi && (s_r.awaddr == pwm_timer_pkg::OFS_CNT0);
   assign ld1 = wr_lo && wr_hi && (s_r.awaddr == pwm_timer_pkg::OFS_CNT1);

   // Per-channel run, clear mode, period and load each feed one counter.
   assign ch_run = {run1, run0};
   assign ch_clear = {1'b1, s_r.clear_sel == pwm_timer_pkg::CLR_SEL_PERIOD};
   assign ch_load = {ld1, ld0};
   assign ch_period[0] = s_r.period;
   assign ch_period[1] = s_r.period1;
   assign cnt0 = cnt_stat[0];
   assign cnt1 = cnt_stat[1];

   genvar ch;
   generate
      for (ch = 0; ch < pwm_timer_pkg::NUM_CH; ch++) begin : g_ch
         timer_counter u_cnt (
            .clk(clk),
            .srst(srst),
            .run(ch_run[ch]),
            .clear_on_period(ch_clear[ch]),
            .period(ch_period[ch]),
            .load_en(ch_load[ch]),
            .load_val(wdata16),
            .stat(cnt_stat[ch])
         );
      end
   endgenerate

   // Match and wrap events of channel 0 that set the status flags.
   assign cmp_val[pwm_timer_pkg::STAT_B_BIT] = s_r.cmp_b;
   assign cmp_val[pwm_timer_pkg::STAT_C_BIT] = s_r.cmp_c;
   assign cmp_val[pwm_timer_pkg::STAT_D_BIT] = s_r.cmp_d;
   assign flag_set[pwm_timer_pkg::STAT_PM_BIT] = cnt0.period_hit;
   assign flag_set[pwm_timer_pkg::STAT_WRAP_BIT] = cnt0.wrap;

   genvar cm;
   generate
      for (cm = pwm_timer_pkg::STAT_B_BIT; cm <= pwm_timer_pkg::STAT_D_BIT; cm++) begin : g_cmp
         assign flag_set[cm] = run0 && (cnt0.value == cmp_val[cm]);
      end
   endgenerate

   // Sticky status flags with the read-then-write-zero clear.
   status_flags u_flags (
      .clk(clk),
      .srst(srst),
      .set(flag_set),
      .rd(stat_rd),
      .wr(stat_wr),
      .wr_data(s_r.wdata[pwm_timer_pkg::NUM_FLAGS-1:0]),
      .flags(flags)
   );

   assign irq_event = |(flag_set & s_r.irq_en);

   // Read data decode for the address offered on the read channel.
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      unique case (axi_req.araddr)
         pwm_timer_pkg::OFS_STATUS: begin
            rd_word[pwm_timer_pkg::NUM_FLAGS-1:0] = flags;
         end
         pwm_timer_pkg::OFS_IRQ_REQ: begin
            rd_word[pwm_timer_pkg::IRQ_CH0_BIT] = s_r.irq_req;
         end
         pwm_timer_pkg::OFS_IRQ_MASK: begin
            rd_word[pwm_timer_pkg::IRQ_CH0_BIT] = s_r.irq_mask;
         end
         pwm_timer_pkg::OFS_START: begin
            rd_word[pwm_timer_pkg::START_W-1:0] = s_r.start;
         end
         pwm_timer_pkg::OFS_CTRL: begin
            rd_word[pwm_timer_pkg::CLR_SEL_LSB +: pwm_timer_pkg::CLR_SEL_W] = s_r.clear_sel;
         end
         pwm_timer_pkg::OFS_IRQ_EN: begin
            rd_word[pwm_timer_pkg::NUM_FLAGS-1:0] = s_r.irq_en;
         end
         pwm_timer_pkg::OFS_PERIOD: begin
            rd_word[pwm_timer_pkg::CNT_W-1:0] = s_r.period;
         end
         pwm_timer_pkg::OFS_CMP_B: begin
            rd_word[pwm_timer_pkg::CNT_W-1:0] = s_r.cmp_b;
         end
         pwm_timer_pkg::OFS_CMP_C: begin
            rd_word[pwm_timer_pkg::CNT_W-1:0] = s_r.cmp_c;
         end
         pwm_timer_pkg::OFS_CMP_D: begin
            rd_word[pwm_timer_pkg::CNT_W-1:0] = s_r.cmp_d;
         end
         pwm_timer_pkg::OFS_CNT0: begin
            rd_word[pwm_timer_pkg::CNT_W-1:0] = cnt0.value;
         end
         pwm_timer_pkg::OFS_PERIOD1: begin
            rd_word[pwm_timer_pkg::CNT_W-1:0] = s_r.period1;
         end
         pwm_timer_pkg::OFS_CNT1: begin
            rd_word[pwm_timer_pkg::CNT_W-1:0] = cnt1.value;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // Write address decode that picks the response code.
   always_comb begin
      wr_hit = 1'b1;
      unique case (s_r.awaddr)
         pwm_timer_pkg::OFS_STATUS,
         pwm_timer_pkg::OFS_IRQ_REQ,
         pwm_timer_pkg::OFS_IRQ_MASK,
         pwm_timer_pkg::OFS_START,
         pwm_timer_pkg::OFS_CTRL,
         pwm_timer_pkg::OFS_IRQ_EN,
         pwm_timer_pkg::OFS_PERIOD,
         pwm_timer_pkg::OFS_CMP_B,
         pwm_timer_pkg::OFS_CMP_C,
         pwm_timer_pkg::OFS_CMP_D,
         pwm_timer_pkg::OFS_CNT0,
         pwm_timer_pkg::OFS_PERIOD1,
         pwm_timer_pkg::OFS_CNT1: begin
            wr_hit = 1'b1;
         end
         default: begin
            wr_hit = 1'b0;
         end
      endcase
   end

   always_comb begin
      s_nxt = s_r;

      // Write address and data are captured independently, then applied together.
      if (axi_req.awvalid && s_r.rsp.awready) begin
         s_nxt.aw_held = 1'b1;
         s_nxt.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && s_r.rsp.wready) begin
         s_nxt.w_held = 1'b1;
         s_nxt.wdata = axi_req.wdata;
         s_nxt.wstrb = axi_req.wstrb;
      end
      if (s_r.rsp.bvalid && axi_req.bready) begin
         s_nxt.rsp.bvalid = 1'b0;
      end

      if (do_write) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held = 1'b0;
         s_nxt.rsp.bvalid = 1'b1;
         s_nxt.rsp.bresp = wr_hit ? pwm_timer_pkg::RESP_OKAY : pwm_timer_pkg::RESP_SLVERR;
         if (wr_lo) begin
            unique case (s_r.awaddr)
               pwm_timer_pkg::OFS_IRQ_MASK: begin
                  s_nxt.irq_mask = s_r.wdata[pwm_timer_pkg::IRQ_CH0_BIT];
               end
               pwm_timer_pkg::OFS_START: begin
                  s_nxt.start = s_r.wdata[pwm_timer_pkg::START_W-1:0];
               end
               pwm_timer_pkg::OFS_CTRL: begin
                  s_nxt.clear_sel =
                     s_r.wdata[pwm_timer_pkg::CLR_SEL_LSB +: pwm_timer_pkg::CLR_SEL_W];
               end
               pwm_timer_pkg::OFS_IRQ_EN: begin
                  s_nxt.irq_en = s_r.wdata[pwm_timer_pkg::NUM_FLAGS-1:0];
               end
               default: begin
               end
            endcase
         end
         if (wr_lo && wr_hi) begin
            unique case (s_r.awaddr)
               pwm_timer_pkg::OFS_PERIOD: begin
                  s_nxt.period = wdata16;
               end
               pwm_timer_pkg::OFS_CMP_B: begin
                  s_nxt.cmp_b = wdata16;
               end
               pwm_timer_pkg::OFS_CMP_C: begin
                  s_nxt.cmp_c = wdata16;
               end
               pwm_timer_pkg::OFS_CMP_D: begin
                  s_nxt.cmp_d = wdata16;
               end
               pwm_timer_pkg::OFS_PERIOD1: begin
                  s_nxt.period1 = wdata16;
               end
               default: begin
               end
            endcase
         end
      end

      // Request flag: writing one clears it, a new event in the same cycle wins.
      if (wr_lo && (s_r.awaddr == pwm_timer_pkg::OFS_IRQ_REQ)
          && s_r.wdata[pwm_timer_pkg::IRQ_CH0_BIT]) begin
         s_nxt.irq_req = 1'b0;
      end
      if (irq_event) begin
         s_nxt.irq_req = 1'b1;
      end

      s_nxt.rsp.awready = !s_nxt.aw_held && !s_nxt.rsp.bvalid;
      s_nxt.rsp.wready = !s_nxt.w_held && !s_nxt.rsp.bvalid;

      // Read channel: one read at a time, answered in the cycle after acceptance.
      if (s_r.rsp.rvalid && axi_req.rready) begin
         s_nxt.rsp.rvalid = 1'b0;
         s_nxt.rsp.arready = 1'b1;
      end
      if (do_read) begin
         s_nxt.rsp.arready = 1'b0;
         s_nxt.rsp.rvalid = 1'b1;
         s_nxt.rsp.rdata = rd_word;
         s_nxt.rsp.rresp = rd_hit ? pwm_timer_pkg::RESP_OKAY : pwm_timer_pkg::RESP_SLVERR;
      end

      s_nxt.irq = s_nxt.irq_req && !s_nxt.irq_mask;
   end

   // Registers all state; reset loads the register defaults.
   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
         s_r.rsp.awready <= 1'b1;
         s_r.rsp.wready <= 1'b1;
         s_r.rsp.arready <= 1'b1;
         s_r.irq_mask <= pwm_timer_pkg::IRQ_MASK_RST;
         s_r.start <= pwm_timer_pkg::START_RST;
         s_r.clear_sel <= pwm_timer_pkg::CLR_SEL_RST;
         s_r.irq_en <= pwm_timer_pkg::IRQ_EN_RST;
         s_r.period <= pwm_timer_pkg::CMP_RST;
         s_r.cmp_b <= pwm_timer_pkg::CMP_RST;
         s_r.cmp_c <= pwm_timer_pkg::CMP_RST;
         s_r.cmp_d <= pwm_timer_pkg::CMP_RST;
         s_r.period1 <= pwm_timer_pkg::CMP_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign axi_rsp = s_r.rsp;
   assign irq = s_r.irq;

endmodule // pwm_timer_match_irq

// ==== tb/irq_ctrl_model.sv ====
// Interrupt controller model that counts level requests taken from the timer.
// Assumes irq is a level from a flop on clk.
`timescale 1ns/1ps
module irq_ctrl_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic irq,
   output logic [7:0] irq_seen
);
   logic irq_d_r;
   // Counts each new request that reaches the CPU side.
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_d_r <= 1'b0;
         irq_seen <= 8'h00;
      end else begin
         irq_d_r <= irq;
         if (irq && !irq_d_r) begin
            irq_seen <= irq_seen + 8'h01;
         end
      end
   end
endmodule // irq_ctrl_model

// ==== tb/pwm_timer_match_irq_checker.sv ====
// Concurrent checks on the register bus and interrupt of the timer block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pwm_timer_match_irq_checker (
   input wire logic clk,
   input wire logic srst,
   input pwm_timer_pkg::axil_req_t axi_req,
   input pwm_timer_pkg::axil_rsp_t axi_rsp,
   input wire logic irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic ar_take;
   logic wr_take;
   logic rd_bad;
   logic [7:0] rd_addr_r;
   logic mask_sh_r;
   assign ar_take = axi_req.arvalid && axi_rsp.arready;
   assign wr_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   assign rd_bad = (rd_addr_r > pwm_timer_pkg::OFS_CNT1) || (rd_addr_r[1:0] != 2'b00);
   // Remembers the read address and the mask bit as software wrote it.
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_addr_r <= 8'h00;
         mask_sh_r <= 1'b1;
      end else begin
         if (ar_take) begin
            rd_addr_r <= axi_req.araddr;
         end
         if (wr_take && axi_req.awaddr == pwm_timer_pkg::OFS_IRQ_MASK && axi_req.wstrb[0]) begin
            mask_sh_r <= axi_req.wdata[pwm_timer_pkg::IRQ_CH0_BIT];
         end
      end
   end
   chk_write_answer: assert property (wr_take |-> ##[1:2] axi_rsp.bvalid)
      else $error("write response missing");
   chk_read_answer: assert property (ar_take |=> axi_rsp.rvalid)
      else $error("read data late");
   chk_b_stands: assert property (axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped");
   chk_r_stands: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
   chk_busy_ready: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      else $error("write accepted while busy");
   chk_bad_read: assert property (axi_rsp.rvalid && rd_bad
      |-> axi_rsp.rresp == pwm_timer_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_good_read: assert property (axi_rsp.rvalid && !rd_bad
      |-> axi_rsp.rresp == pwm_timer_pkg::RESP_OKAY) else $error("mapped read refused");
   chk_status_layout: assert property (
      axi_rsp.rvalid && rd_addr_r == pwm_timer_pkg::OFS_STATUS |-> axi_rsp.rdata[31:5] == 27'h0)
      else $error("status upper bits set");
   chk_request_layout: assert property (
      axi_rsp.rvalid && rd_addr_r == pwm_timer_pkg::OFS_IRQ_REQ
      |-> axi_rsp.rdata[31:2] == 30'h0 && !axi_rsp.rdata[0]) else $error("request layout wrong");
   chk_mask_blocks: assert property (irq |-> !$past(mask_sh_r))
      else $error("interrupt while masked");
   cov_irq: cover property ($rose(irq));
   cov_bad_read: cover property (axi_rsp.rvalid && rd_bad);
   cov_status_read: cover property (axi_rsp.rvalid && rd_addr_r == pwm_timer_pkg::OFS_STATUS);
endmodule // pwm_timer_match_irq_checker

bind pwm_timer_match_irq pwm_timer_match_irq_checker u_chk (.clk(clk), .srst(srst),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .irq(irq));

// ==== tb/pwm_timer_match_irq_tb.sv ====
// Self-checking bench of the timer block, driving registers over AXI4-Lite.
// Assumes the block answers every request and the model counts interrupts.
`timescale 1ns/1ps
module pwm_timer_match_irq_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   pwm_timer_pkg::axil_req_t req = '0;
   pwm_timer_pkg::axil_rsp_t rsp;
   logic irq;
   logic [7:0] irq_seen;
   logic [31:0] rdat;
   logic [1:0] rresp_v;
   logic [1:0] bresp_v;
   int miscompares = 0;
   int comparisons = 0;

   always #2.5 clk = ~clk;

   pwm_timer_match_irq u_dut (.clk(clk), .srst(srst), .axi_req(req), .axi_rsp(rsp), .irq(irq));
   irq_ctrl_model u_intc (.clk(clk), .srst(srst), .irq(irq), .irq_seen(irq_seen));

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic aw_ok;
      logic w_ok;
      n = 0;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      while (!(aw_ok && w_ok) && n < 100) begin
         @(posedge clk);
         n++;
         if (!aw_ok && rsp.awready === 1'b1) begin
            aw_ok = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (!w_ok && rsp.wready === 1'b1) begin
            w_ok = 1'b1;
            req.wvalid <= 1'b0;
         end
      end
      do begin
         @(posedge clk);
         n++;
      end while (rsp.bvalid !== 1'b1 && n < 100);
      bresp_v = rsp.bresp;
      req.bready <= 1'b0;
      check("write answered", 32'h1, {31'h0, n < 100});
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.arready !== 1'b1 && n < 100);
      req.arvalid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.rvalid !== 1'b1 && n < 100);
      rdat = rsp.rdata;
      rresp_v = rsp.rresp;
      req.rready <= 1'b0;
      check("read answered", 32'h1, {31'h0, n < 100});
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      rd(a);
      check(nm, e, rdat & m);
   endtask

   task automatic t_reset();
      logic [7:0] ad [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h28, 8'h1c};
      logic [31:0] ex [9] = '{0, 0, 32'h2, 0, 0, 0, 32'hffff, 0, 32'hffff};
      for (int i = 0; i < 9; i++) begin
         rdc("reset value", ad[i], 32'hffffffff, ex[i]);
      end
      rdc("unmapped read", 8'h40, 32'hffffffff, 32'h0);
      check("unmapped read resp", {30'h0, pwm_timer_pkg::RESP_SLVERR}, {30'h0, rresp_v});
      wr(8'h40, 32'h1);
      check("unmapped write resp", {30'h0, pwm_timer_pkg::RESP_SLVERR}, {30'h0, bresp_v});
   endtask

   task automatic t_period_irq();
      int n;
      wr(pwm_timer_pkg::OFS_PERIOD, 32'h5);
      wr(pwm_timer_pkg::OFS_CTRL, 32'h20);
      wr(pwm_timer_pkg::OFS_IRQ_EN, 32'h1);
      rd(pwm_timer_pkg::OFS_STATUS);
      wr(pwm_timer_pkg::OFS_STATUS, 32'h0);
      wr(pwm_timer_pkg::OFS_IRQ_REQ, 32'h2);
      wr(pwm_timer_pkg::OFS_IRQ_MASK, 32'h0);
      wr(pwm_timer_pkg::OFS_START, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      check("irq raised", 32'h1, {31'h0, irq});
      wr(pwm_timer_pkg::OFS_START, 32'h0);
      rd(pwm_timer_pkg::OFS_CNT0);
      check("count cleared at period", 32'h1, {31'h0, rdat[15:0] <= 16'h0005});
      rdc("count stopped", pwm_timer_pkg::OFS_CNT0, 32'hffff, rdat);
      wr(pwm_timer_pkg::OFS_STATUS, 32'h1f);
      wr(pwm_timer_pkg::OFS_STATUS, 32'h0);
      rdc("flag kept without read", pwm_timer_pkg::OFS_STATUS, 32'h1, 32'h1);
      wr(pwm_timer_pkg::OFS_STATUS, 32'h0);
      rdc("flag cleared", pwm_timer_pkg::OFS_STATUS, 32'h1, 32'h0);
      check("irq held", 32'h1, {31'h0, irq});
      check("controller saw one", 32'h1, {24'h0, irq_seen});
      wr(pwm_timer_pkg::OFS_IRQ_MASK, 32'h2);
      repeat (2) @(posedge clk);
      check("irq masked", 32'h0, {31'h0, irq});
      rdc("request pending", pwm_timer_pkg::OFS_IRQ_REQ, 32'hffffffff, 32'h2);
      wr(pwm_timer_pkg::OFS_IRQ_REQ, 32'h2);
      rdc("request cleared", pwm_timer_pkg::OFS_IRQ_REQ, 32'hffffffff, 32'h0);
      wr(pwm_timer_pkg::OFS_IRQ_MASK, 32'h0);
   endtask

   task automatic t_enable_off();
      wr(pwm_timer_pkg::OFS_IRQ_EN, 32'h0);
      wr(pwm_timer_pkg::OFS_CNT0, 32'h0);
      wr(pwm_timer_pkg::OFS_START, 32'h1);
      repeat (20) @(posedge clk);
      wr(pwm_timer_pkg::OFS_START, 32'h0);
      rdc("match flag set", pwm_timer_pkg::OFS_STATUS, 32'h1, 32'h1);
      wr(pwm_timer_pkg::OFS_STATUS, 32'h0);
      rdc("no request", pwm_timer_pkg::OFS_IRQ_REQ, 32'hffffffff, 32'h0);
      check("irq quiet", 32'h0, {31'h0, irq});
   endtask

   task automatic t_overflow_ch1();
      wr(pwm_timer_pkg::OFS_CTRL, 32'h0);
      wr(pwm_timer_pkg::OFS_PERIOD, 32'hffff);
      wr(pwm_timer_pkg::OFS_CNT0, 32'hfff0);
      wr(pwm_timer_pkg::OFS_START, 32'h3);
      repeat (30) @(posedge clk);
      wr(pwm_timer_pkg::OFS_START, 32'h0);
      rdc("overflow flag", pwm_timer_pkg::OFS_STATUS, 32'h10, 32'h10);
      rd(pwm_timer_pkg::OFS_CNT1);
      check("second channel runs", 32'h1, {31'h0, rdat != 32'h0});
   endtask

   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      results();
   end

   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_period_irq();
      t_enable_off();
      t_overflow_ch1();
      results();
   end
endmodule // pwm_timer_match_irq_tb
